/* File: src/tmr_top.sv */
// Top of the 8-bit timer/counter: APB registers, counter, compare and flags
//
// What this block does
// RQ1: Force bit A in non-PWM mode applies compare action to output A.
// RQ2: Force bit B in non-PWM mode applies compare action to output B.
// RQ3: Forced strobes never set flags nor clear the counter in CTC.
// RQ4: Force bits are strobes, store nothing, always read zero.
// RQ5: Software keeps force bits zero when writing in PWM modes.
// RQ6: Clock select picks stop, clk, clk/8/64/256/1024, or pin fall/rise.
// RQ7: Pin edges count even when that pin is an output.
// RQ8: Reserved bits of control B, mask and flags ignore writes, read zero.
// RQ9: Counter register is directly readable and writable.
// RQ10: Counter write blocks the compare match on the next tick.
// RQ11: Both compare registers are compared continuously with the counter.
// RQ12: Flag bit 2 sets on compare B match.
// RQ13: Flag bit 1 sets on compare A match.
// RQ14: Flag bit 0 sets on overflow, point depending on waveform mode.
// RQ15: Flags clear by hardware when their vector is taken.
// RQ16: Writing one clears a flag; zero leaves it.
// RQ17: Mask enables bits 2..0; request needs enable, flag and global bit.
// RQ18: Wave mode picks normal, phase-correct, CTC or fast PWM and top.
// RQ19: Non-PWM compare codes: disconnect, toggle, clear, set.
// RQ20: Each tick advances the counter; normal mode wraps max to zero.
`timescale 1ns/1ps
`default_nettype none
module tmr_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_count_pin,
  input wire logic cpu_global_irq_en,
  input wire logic [2:0] vector_ack,
  output logic wave_out_a,
  output logic wave_out_b,
  output logic [2:0] irq_req
);
  import tmr_pkg::*;

  logic [7:0] ctrl_a_r;
  logic [7:0] ctrl_b_r;
  logic [7:0] counter_value_r;
  logic [7:0] cmp_a_r;
  logic [7:0] cmp_b_r;
  logic [7:0] cmp_a_buf_r;
  logic [7:0] cmp_b_buf_r;
  logic [2:0] mask_r;
  logic [2:0] flags_r;
  logic block_r;
  logic down_r;
  logic force_a;
  logic force_b;
  logic tick;
  logic [7:0] top;
  logic [7:0] cnt_nxt;
  logic down_nxt;
  logic match_a;
  logic match_b;
  logic ovf;
  logic acc;
  logic wr;
  logic rd;
  logic map_hit;
  logic cnt_wr;
  logic [7:0] idx;
  logic [7:0] rdata;
  tmr_cfg_s cfg;
  tmr_wm_e mode;
  logic wave_a;
  logic wave_b;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = a == b;
  endfunction : hit

  function automatic logic is_pwm(input tmr_wm_e m);
    is_pwm = !(m == TMR_WM_NORMAL || m == TMR_WM_CTC);
  endfunction : is_pwm

  assign idx = paddr[9:2];
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign cfg = '{com_a: ctrl_a_r[7:6], com_b: ctrl_a_r[5:4],
                 wave_mode_select: {ctrl_b_r[TMR_WGM2_BIT], ctrl_a_r[1:0]},
                 clock_source_select: ctrl_b_r[2:0]};
  assign mode = tmr_wm_e'(cfg.wave_mode_select);
  assign cnt_wr = wr && hit(idx, TMR_IDX_COUNT);

  always_comb begin
    map_hit = hit(idx, TMR_IDX_CTRL_A) || hit(idx, TMR_IDX_CTRL_B) ||
              hit(idx, TMR_IDX_COUNT) || hit(idx, TMR_IDX_CMP_A) ||
              hit(idx, TMR_IDX_CMP_B) || hit(idx, TMR_IDX_MASK) ||
              hit(idx, TMR_IDX_FLAGS);
  end

  // Force strobes decoded straight off the write, never stored
  assign force_a = wr && hit(idx, TMR_IDX_CTRL_B) && pwdata[TMR_FOC_A_BIT] && !is_pwm(mode); // RQ1 RQ4
  assign force_b = wr && hit(idx, TMR_IDX_CTRL_B) && pwdata[TMR_FOC_B_BIT] && !is_pwm(mode); // RQ2 RQ4

  tmr_prescale u_pre (
    .pclk(pclk),
    .presetn(presetn),
    .clock_source_select(cfg.clock_source_select),
    .ext_count_pin(ext_count_pin),
    .tick(tick)
  );

  // Top is fixed 0xff or compare A, per mode
  always_comb begin
    unique case (mode) // RQ18
      TMR_WM_CTC, TMR_WM_PC_OCA, TMR_WM_FAST_OCA: top = cmp_a_r;
      default: top = TMR_MAX;
    endcase
  end

  // Matches are qualified by the tick and the write-block flag
  assign match_a = tick && !block_r && hit(counter_value_r, cmp_a_r); // RQ10 RQ11
  assign match_b = tick && !block_r && hit(counter_value_r, cmp_b_r); // RQ10 RQ11

  always_comb begin
    cnt_nxt = counter_value_r;
    down_nxt = down_r;
    ovf = 1'b0;
    if (tick) begin
      unique case (mode)
        TMR_WM_PC_FF, TMR_WM_PC_OCA: begin
          if (!down_r && counter_value_r >= top) begin
            down_nxt = 1'b1;
            cnt_nxt = counter_value_r - 8'h01;
          end else if (down_r && counter_value_r == TMR_BOTTOM) begin
            down_nxt = 1'b0;
            cnt_nxt = counter_value_r + 8'h01;
            ovf = 1'b1; // RQ14
          end else begin
            cnt_nxt = down_r ? counter_value_r - 8'h01 : counter_value_r + 8'h01;
          end
        end
        TMR_WM_CTC: begin
          // Only a real match clears; a forced strobe never does
          cnt_nxt = match_a ? TMR_BOTTOM : counter_value_r + 8'h01; // RQ3
          ovf = counter_value_r == TMR_MAX; // RQ14
        end
        TMR_WM_FAST_OCA: begin
          cnt_nxt = (counter_value_r >= top) ? TMR_BOTTOM : counter_value_r + 8'h01;
          ovf = counter_value_r == top; // RQ14
        end
        default: begin
          cnt_nxt = counter_value_r + 8'h01; // RQ20
          ovf = counter_value_r == TMR_MAX; // RQ14
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_value_r <= TMR_RESET_VAL;
      down_r <= 1'b0;
    end else if (cnt_wr) begin
      counter_value_r <= pwdata[7:0]; // RQ9
      down_r <= down_r;
    end else begin
      counter_value_r <= cnt_nxt;
      down_r <= is_pwm(mode) ? down_nxt : 1'b0;
    end
  end

  // Held from the write until the following tick has been consumed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_r <= 1'b0;
    end else if (cnt_wr) begin
      block_r <= 1'b1; // RQ10
    end else if (tick) begin
      block_r <= 1'b0;
    end
  end

  // PWM modes update compares at top or bottom; others at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_a_r <= TMR_RESET_VAL;
      cmp_b_r <= TMR_RESET_VAL;
    end else if (!is_pwm(mode) || (tick && ((mode == TMR_WM_FAST_OCA) ?
                 counter_value_r == TMR_BOTTOM : counter_value_r == top))) begin
      cmp_a_r <= cmp_a_buf_r; // RQ18
      cmp_b_r <= cmp_b_buf_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_a_r <= TMR_RESET_VAL;
      ctrl_b_r <= TMR_RESET_VAL;
      cmp_a_buf_r <= TMR_RESET_VAL;
      cmp_b_buf_r <= TMR_RESET_VAL;
      mask_r <= 3'h0;
    end else if (wr) begin
      if (hit(idx, TMR_IDX_CTRL_A)) ctrl_a_r <= pwdata[7:0] & TMR_CTRL_A_WMASK;
      if (hit(idx, TMR_IDX_CTRL_B)) ctrl_b_r <= pwdata[7:0] & TMR_CTRL_B_WMASK; // RQ4 RQ8
      if (hit(idx, TMR_IDX_CMP_A)) cmp_a_buf_r <= pwdata[7:0];
      if (hit(idx, TMR_IDX_CMP_B)) cmp_b_buf_r <= pwdata[7:0];
      if (hit(idx, TMR_IDX_MASK)) mask_r <= pwdata[2:0] & TMR_IRQ_WMASK[2:0]; // RQ8 RQ17
    end
  end

  // Hardware set beats any clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if ((i == TMR_OVF_BIT && ovf) || (i == TMR_CMPA_BIT && match_a) ||
            (i == TMR_CMPB_BIT && match_b)) begin
          flags_r[i] <= 1'b1; // RQ12 RQ13 RQ14
        end else if (vector_ack[i] ||
                     (wr && hit(idx, TMR_IDX_FLAGS) && pwdata[i])) begin
          flags_r[i] <= 1'b0; // RQ15 RQ16
        end
      end
    end
  end

  tmr_wave u_wave_a (
    .pclk(pclk),
    .presetn(presetn),
    .com(cfg.com_a),
    .mode(cfg.wave_mode_select),
    .match(match_a),
    .force_cmp(force_a),
    .at_bottom(tick && counter_value_r == TMR_BOTTOM),
    .at_top(tick && counter_value_r == top),
    .down(down_r),
    .is_top_reg(1'b0),
    .wave_r(wave_a)
  );

  tmr_wave u_wave_b (
    .pclk(pclk),
    .presetn(presetn),
    .com(cfg.com_b),
    .mode(cfg.wave_mode_select),
    .match(match_b),
    .force_cmp(force_b),
    .at_bottom(tick && counter_value_r == TMR_BOTTOM),
    .at_top(tick && counter_value_r == top),
    .down(down_r),
    .is_top_reg(mode[2] && hit(cmp_b_r, top)),
    .wave_r(wave_b)
  );

  always_comb begin
    rdata = 8'h00;
    if (hit(idx, TMR_IDX_CTRL_A)) rdata = ctrl_a_r;
    if (hit(idx, TMR_IDX_CTRL_B)) rdata = ctrl_b_r & TMR_CTRL_B_WMASK; // RQ4 RQ8
    if (hit(idx, TMR_IDX_COUNT)) rdata = counter_value_r; // RQ9
    if (hit(idx, TMR_IDX_CMP_A)) rdata = cmp_a_buf_r;
    if (hit(idx, TMR_IDX_CMP_B)) rdata = cmp_b_buf_r;
    if (hit(idx, TMR_IDX_MASK)) rdata = {5'h00, mask_r}; // RQ8
    if (hit(idx, TMR_IDX_FLAGS)) rdata = {5'h00, flags_r}; // RQ8
  end

  // Zero-wait slave: pready is a flop high during each access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !map_hit;
      prdata <= (psel && !penable && !pwrite) ? {24'h00_0000, rdata} : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req <= 3'h0;
      wave_out_a <= 1'b0;
      wave_out_b <= 1'b0;
    end else begin
      irq_req <= flags_r & mask_r & {3{cpu_global_irq_en}}; // RQ17
      wave_out_a <= wave_a;
      wave_out_b <= wave_b;
    end
  end

  logic unused_ok;
  assign unused_ok = rd;
endmodule : tmr_top
`default_nettype wire

/* File: src/tmr_pkg.sv */
// Package of register map, field positions and timing constants for the 8-bit timer
package tmr_pkg;
  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] TMR_IDX_CTRL_B = 8'h25;
  localparam logic [7:0] TMR_IDX_CMP_B = 8'h28;
  localparam logic [7:0] TMR_IDX_MASK = 8'h6e;
  localparam logic [7:0] TMR_IDX_CTRL_A = 8'h24;
  localparam logic [7:0] TMR_IDX_COUNT = 8'h26;
  localparam logic [7:0] TMR_IDX_CMP_A = 8'h27;
  localparam logic [7:0] TMR_IDX_FLAGS = 8'h35;
  localparam logic [7:0] TMR_IDX_IRQ = 8'h3f;
  // Control B fields
  localparam int TMR_FOC_A_BIT = 7;
  localparam int TMR_FOC_B_BIT = 6;
  localparam int TMR_WGM2_BIT = 3;
  localparam logic [7:0] TMR_CTRL_B_WMASK = 8'h0f;
  localparam logic [7:0] TMR_CTRL_A_WMASK = 8'hf3;
  localparam logic [7:0] TMR_IRQ_WMASK = 8'h07;
  // Flag and enable positions
  localparam int TMR_OVF_BIT = 0;
  localparam int TMR_CMPA_BIT = 1;
  localparam int TMR_CMPB_BIT = 2;
  localparam logic [7:0] TMR_RESET_VAL = 8'h00;
  localparam logic [7:0] TMR_MAX = 8'hff;
  localparam logic [7:0] TMR_BOTTOM = 8'h00;
  // Prescaler taps
  localparam int TMR_PRE_W = 10;
  localparam logic [9:0] TMR_DIV8_MASK = 10'h007;
  localparam logic [9:0] TMR_DIV64_MASK = 10'h03f;
  localparam logic [9:0] TMR_DIV256_MASK = 10'h0ff;
  localparam logic [9:0] TMR_DIV1024_MASK = 10'h3ff;

  typedef enum logic [2:0] {
    TMR_CS_STOP = 3'h0, TMR_CS_DIV1 = 3'h1, TMR_CS_DIV8 = 3'h2, TMR_CS_DIV64 = 3'h3,
    TMR_CS_DIV256 = 3'h4, TMR_CS_DIV1024 = 3'h5, TMR_CS_EXT_FALL = 3'h6, TMR_CS_EXT_RISE = 3'h7
  } tmr_cs_e;

  typedef enum logic [2:0] {
    TMR_WM_NORMAL = 3'h0, TMR_WM_PC_FF = 3'h1, TMR_WM_CTC = 3'h2, TMR_WM_FAST_FF = 3'h3,
    TMR_WM_RES4 = 3'h4, TMR_WM_PC_OCA = 3'h5, TMR_WM_RES6 = 3'h6, TMR_WM_FAST_OCA = 3'h7
  } tmr_wm_e;

  typedef struct packed {
    logic [1:0] com_a;
    logic [1:0] com_b;
    logic [2:0] wave_mode_select;
    logic [2:0] clock_source_select;
  } tmr_cfg_s;

  typedef struct packed {
    logic [7:0] paddr;
    logic pwrite;
    logic [31:0] pwdata;
  } tmr_req_s;
endpackage : tmr_pkg

/* File: src/tmr_prescale.sv */
// Prescaler and clock-source selection producing a one-cycle timer tick
`timescale 1ns/1ps
`default_nettype none
module tmr_prescale (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] clock_source_select,
  input wire logic ext_count_pin,
  output logic tick
);
  import tmr_pkg::*;

  logic [TMR_PRE_W-1:0] pre_r;
  logic sync1_r;
  logic sync2_r;
  logic sync3_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + 10'h001;
    end
  end

  // Pin sampled regardless of its direction, so software can toggle it to count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
    end else begin
      sync1_r <= ext_count_pin; // RQ7
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  always_comb begin
    unique case (tmr_cs_e'(clock_source_select)) // RQ6
      TMR_CS_STOP: tick = 1'b0;
      TMR_CS_DIV1: tick = 1'b1;
      TMR_CS_DIV8: tick = (pre_r & TMR_DIV8_MASK) == TMR_DIV8_MASK;
      TMR_CS_DIV64: tick = (pre_r & TMR_DIV64_MASK) == TMR_DIV64_MASK;
      TMR_CS_DIV256: tick = (pre_r & TMR_DIV256_MASK) == TMR_DIV256_MASK;
      TMR_CS_DIV1024: tick = pre_r == TMR_DIV1024_MASK;
      TMR_CS_EXT_FALL: tick = sync3_r & ~sync2_r;
      TMR_CS_EXT_RISE: tick = ~sync3_r & sync2_r;
    endcase
  end
endmodule : tmr_prescale
`default_nettype wire

/* File: src/tmr_wave.sv */
// Compare-output action unit for one waveform channel
`timescale 1ns/1ps
`default_nettype none
module tmr_wave (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] com,
  input wire logic [2:0] mode,
  input wire logic match,
  input wire logic force_cmp,
  input wire logic at_bottom,
  input wire logic at_top,
  input wire logic down,
  input wire logic is_top_reg,
  output logic wave_r
);
  import tmr_pkg::*;

  logic nonpwm;
  logic fast;
  assign nonpwm = (mode == TMR_WM_NORMAL) || (mode == TMR_WM_CTC);
  assign fast = (mode == TMR_WM_FAST_FF) || (mode == TMR_WM_FAST_OCA);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_r <= 1'b0;
    end else if (nonpwm) begin
      if (match || force_cmp) begin // RQ1 RQ2 RQ19
        unique case (com)
          2'b00: wave_r <= wave_r;
          2'b01: wave_r <= ~wave_r;
          2'b10: wave_r <= 1'b0;
          2'b11: wave_r <= 1'b1;
        endcase
      end
    end else if (com[1]) begin
      // In fast PWM a match with is_top_reg set (compare B equal to a compare-A top) is ignored; only the period edge acts then
      if (fast) begin
        if (at_bottom) wave_r <= ~com[0];
        else if (match && !is_top_reg) wave_r <= com[0];
      end else if (match && !(is_top_reg && !at_top)) begin
        wave_r <= down ? ~com[0] : com[0];
      end
    end else if (com[0] && mode[2] && match) begin
      wave_r <= ~wave_r;
    end
  end
endmodule : tmr_wave
`default_nettype wire

/* File: sim/tmr_top_asserts.sv */
// Checker of the timer block's port behaviour
`timescale 1ns/1ps
`default_nettype none
module tmr_top_asserts
  import tmr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ext_count_pin,
  input wire logic cpu_global_irq_en,
  input wire logic [2:0] vector_ack,
  input wire logic wave_out_a,
  input wire logic wave_out_b,
  input wire logic [2:0] irq_req
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd_ok;
  assign rd_ok = pready && !pwrite && !pslverr;

  ready_after_setup_a: assert property (psel && !penable |=> pready && penable)
    else $error("no answer after setup");
  ready_single_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  idle_data_zero_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  ctrl_read_zero_a: assert property (rd_ok && paddr == {TMR_IDX_CTRL_B, 2'b00}
    |-> prdata[7:4] == 4'h0)
    else $error("force or reserved bits read back");
  mask_read_zero_a: assert property (rd_ok && paddr == {TMR_IDX_MASK, 2'b00}
    |-> prdata[7:3] == 5'h0)
    else $error("mask reserved bits read back");
  flag_read_zero_a: assert property (rd_ok && paddr == {TMR_IDX_FLAGS, 2'b00}
    |-> prdata[7:3] == 5'h0)
    else $error("flag reserved bits read back");
  irq_needs_global_a: assert property (irq_req != 3'h0 |-> $past(cpu_global_irq_en))
    else $error("request without global enable");

  flag_read_c: cover property (rd_ok && paddr == {TMR_IDX_FLAGS, 2'b00} && prdata[2:0] != 3'h0);
  irq_seen_c: cover property (irq_req == 3'h7);
  refused_c: cover property (pslverr);
endmodule : tmr_top_asserts
`default_nettype wire

/* File: sim/tmr_top_tb.sv */
// Self-checking testbench of the timer block over APB
`timescale 1ns/1ps
`default_nettype none
module tmr_top_tb;
  import tmr_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_count_pin, glob;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [2:0] vector_ack, irq_req;
  logic wave_out_a, wave_out_b, rerr;
  int error_cnt, num_checks;
  logic [7:0] codes [4] = '{8'h3, 8'h2, 8'h1, 8'h1};
  logic [31:0] waves [4] = '{32'h1, 32'h0, 32'h1, 32'h0};
  int divs [5] = '{1, 8, 64, 256, 1024};

  tmr_top tmr_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_count_pin(ext_count_pin), .cpu_global_irq_en(glob),
    .vector_ack(vector_ack), .wave_out_a(wave_out_a), .wave_out_b(wave_out_b),
    .irq_req(irq_req));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  function automatic logic [9:0] ad(input logic [7:0] idx);
    return {idx, 2'b00};
  endfunction : ad

  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val

  task automatic check_near(input logic [31:0] got, input int exp);
    num_checks++;
    if ($isunknown(got) || int'(got) < exp - 4 || int'(got) > exp + 4) begin
      error_cnt++;
      $display("mismatch at %0t: count %h near %0d expected", $time, got, exp);
    end
  endtask : check_near

  // Bus cycle; a dead slave is caught by the watchdog, not here
  task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, ad(idx), {24'h0, d});
  endtask : wr

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
    apb(1'b0, ad(idx), 32'h0);
    check_val(rdat, {24'h0, e});
  endtask : rd_chk

  initial begin
    repeat (80000) @(posedge pclk);
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    test_done();
  end

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, ext_count_pin, glob} = 5'h0;
    paddr = 10'h0;
    pwdata = 32'h0;
    vector_ack = 3'h0;
    error_cnt = 0;
    num_checks = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(TMR_IDX_CTRL_B, 8'h00);
    rd_chk(TMR_IDX_CMP_B, 8'h00);
    rd_chk(TMR_IDX_MASK, 8'h00);
    wr(TMR_IDX_MASK, 8'hff);
    rd_chk(TMR_IDX_MASK, 8'h07);
    wr(TMR_IDX_MASK, 8'h00);
    wr(TMR_IDX_CTRL_B, 8'h30);
    rd_chk(TMR_IDX_CTRL_B, 8'h00);
    apb(1'b1, 10'h3fc, 32'hff);
    check_val({31'h0, rerr}, 32'h1);
    apb(1'b0, 10'h3fc, 32'h0);
    check_val(rdat, 32'h0);
    // Forced compares in CTC mode with counter equal to top
    wr(TMR_IDX_CMP_A, 8'h05);
    wr(TMR_IDX_COUNT, 8'h05);
    for (int ch = 0; ch < 2; ch++) begin
      for (int i = 0; i < 4; i++) begin
        wr(TMR_IDX_CTRL_A, (codes[i] << (6 - 2 * ch)) | 8'h02);
        wr(TMR_IDX_CTRL_B, 8'h80 >> ch);
        repeat (2) @(posedge pclk);
        check_val({31'h0, ch == 0 ? wave_out_a : wave_out_b}, waves[i]);
      end
    end
    rd_chk(TMR_IDX_CTRL_B, 8'h00);
    rd_chk(TMR_IDX_COUNT, 8'h05);
    rd_chk(TMR_IDX_FLAGS, 8'h00);
    // Counter written to the compare value: first tick must not match
    wr(TMR_IDX_CTRL_A, 8'h00);
    wr(TMR_IDX_CMP_A, 8'h20);
    wr(TMR_IDX_CMP_B, 8'h40);
    wr(TMR_IDX_COUNT, 8'h20);
    rd_chk(TMR_IDX_COUNT, 8'h20);
    wr(TMR_IDX_CTRL_B, 8'h01);
    wr(TMR_IDX_CTRL_B, 8'h00);
    rd_chk(TMR_IDX_FLAGS, 8'h00);
    // Full wrap sets all three flags
    wr(TMR_IDX_COUNT, 8'h00);
    wr(TMR_IDX_MASK, 8'h07);
    glob <= 1'b1;
    wr(TMR_IDX_CTRL_B, 8'h01);
    repeat (300) @(posedge pclk);
    wr(TMR_IDX_CTRL_B, 8'h00);
    rd_chk(TMR_IDX_FLAGS, 8'h07);
    check_val({29'h0, irq_req}, 32'h7);
    vector_ack <= 3'h1;
    @(posedge pclk);
    vector_ack <= 3'h0;
    repeat (3) @(posedge pclk);
    check_val({29'h0, irq_req}, 32'h6);
    rd_chk(TMR_IDX_FLAGS, 8'h06);
    wr(TMR_IDX_FLAGS, 8'h02);
    rd_chk(TMR_IDX_FLAGS, 8'h04);
    wr(TMR_IDX_FLAGS, 8'h00);
    rd_chk(TMR_IDX_FLAGS, 8'h04);
    glob <= 1'b0;
    repeat (3) @(posedge pclk);
    check_val({29'h0, irq_req}, 32'h0);
    glob <= 1'b1;
    wr(TMR_IDX_MASK, 8'h03);
    repeat (3) @(posedge pclk);
    check_val({29'h0, irq_req}, 32'h0);
    wr(TMR_IDX_MASK, 8'h04);
    repeat (3) @(posedge pclk);
    check_val({29'h0, irq_req}, 32'h4);
    wr(TMR_IDX_FLAGS, 8'h07);
    // Prescaler taps: forty ticks each; tolerance covers prescaler phase
    for (int k = 0; k < 5; k++) begin
      wr(TMR_IDX_COUNT, 8'h00);
      wr(TMR_IDX_CTRL_B, 8'(k + 1));
      repeat (40 * divs[k]) @(posedge pclk);
      wr(TMR_IDX_CTRL_B, 8'h00);
      apb(1'b0, ad(TMR_IDX_COUNT), 32'h0);
      check_near(rdat, 40);
    end
    // Pin edges: five toggles give three edges of the first kind
    for (int k = 0; k < 2; k++) begin
      ext_count_pin <= (k == 0);
      repeat (8) @(posedge pclk);
      wr(TMR_IDX_COUNT, 8'h00);
      wr(TMR_IDX_CTRL_B, 8'(6 + k));
      repeat (5) begin
        ext_count_pin <= ~ext_count_pin;
        repeat (8) @(posedge pclk);
      end
      wr(TMR_IDX_CTRL_B, 8'h00);
      rd_chk(TMR_IDX_COUNT, 8'h03);
    end
    test_done();
  end
endmodule : tmr_top_tb

bind tmr_top tmr_top_asserts tmr_top_asserts_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_count_pin(ext_count_pin),
  .cpu_global_irq_en(cpu_global_irq_en), .vector_ack(vector_ack), .wave_out_a(wave_out_a),
  .wave_out_b(wave_out_b), .irq_req(irq_req));
`default_nettype wire
